// >>> design/cal_reset_ctrl.sv
// Calibration sequencer, coefficient store and reset control
//
// Contract
// - Aux offset command: average sixteen samples into 16-bit aux offset.
// - Primary gain command: average sixteen, compute 24-bit gain to full scale.
// - Aux gain command: compute gain to full scale, store 16-bit.
// - Data-ready high on primary calibration accept, low when stored.
// - Primary calibration time follows data rate and filter type.
// - New coefficient stored and applied to following results.
// - Any reset restores register defaults and restarts conversions.
// - Reset sets flag in status bit 0 and power bit 4.
// - Writing 0 clears the flag; only a new reset sets it.
// - Operational 65536 master clocks after power-on threshold.
// - Coefficients at their addresses, least significant byte first.
// - Primary output is offset-corrected, gain-scaled, clipped to 32 bits; aux output clipped to 24 bits.
// - Primary offset coefficient not applied while chop mode enabled; aux offset always applied.
`timescale 1ns/10ps
`default_nettype none
`include "cal_reset_defs.svh"

module cal_reset_ctrl #(
  parameter int POR_DELAY = `POR_DELAY_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             link_clk,
  input  wire logic             reset_powerdown_pin,
  input  wire logic             cmd_valid,
  input  wire cal_pkg::cmd_op_e cmd_op,
  input  wire logic [7:0]       cmd_addr,
  input  wire logic [7:0]       cmd_data,
  input  wire logic             chop_enable,
  input  wire logic             primary_sample_valid,
  input  wire logic [31:0]      primary_sample,
  input  wire logic             aux_sample_valid,
  input  wire logic [23:0]      aux_sample,
  input  wire logic [7:0]       rd_addr,
  output logic [7:0]            rd_data,
  output logic                  data_ready_n,
  output logic [31:0]           primary_result,
  output logic                  primary_result_valid,
  output logic [23:0]           aux_result,
  output logic                  aux_result_valid,
  output logic                  aux_cal_busy,
  output logic                  reset_flag,
  output logic [7:0]            status_byte,
  output logic [7:0]            power_reg,
  output logic                  operational,
  output logic                  conv_restart
);

  typedef struct packed {
    logic                   tog_meta;
    logic                   tog_sync;
    logic                   tog_seen;
    logic                   pin_meta;
    logic                   pin_sync;
    logic [`POR_COUNT_W-1:0] por_count;
    logic                   operational;
    cal_pkg::cal_state_e    state;
    cal_pkg::cmd_op_e       kind;
    logic [4:0]             count;
    logic signed [35:0]     accum;
    logic [55:0]            dividend;
    logic [32:0]            divisor;
    logic [32:0]            rem;
    logic [55:0]            quot;
    logic [5:0]             step;
    logic [23:0]            pri_ofs;
    logic [23:0]            pri_gain;
    logic [15:0]            aux_ofs;
    logic [15:0]            aux_gain;
    logic                   reset_flag;
    logic                   data_ready_n;
    logic [31:0]            pri_res;
    logic                   pri_valid;
    logic [23:0]            aux_res;
    logic                   aux_valid;
    logic                   aux_busy;
    logic                   restart;
    logic [7:0]             rd_data;
  } ctrl_s;

  ctrl_s             st;
  ctrl_s             next_st;
  logic              link_toggle;
  cal_pkg::cmd_op_e  held_op;
  logic [7:0]        held_addr;
  logic [7:0]        held_data;

  link_cmd_port u_link (
    .link_clk   (link_clk),
    .rst_b      (rst_b),
    .cmd_valid  (cmd_valid),
    .cmd_op     (cmd_op),
    .cmd_addr   (cmd_addr),
    .cmd_data   (cmd_data),
    .cmd_toggle (link_toggle),
    .held_op    (held_op),
    .held_addr  (held_addr),
    .held_data  (held_data)
  );

  // ----------------------------------------------------------------
  // Correction datapath
  // ----------------------------------------------------------------
  logic signed [31:0] ofs_term;
  logic signed [32:0] pri_diff;
  logic signed [57:0] pri_prod;
  logic signed [35:0] pri_scaled;
  logic [31:0]        pri_clip;
  logic signed [24:0] aux_diff;
  logic signed [41:0] aux_prod;
  logic signed [27:0] aux_scaled;
  logic [23:0]        aux_clip;

  always_comb begin
    ofs_term   = chop_enable ? '0 : $signed({st.pri_ofs, 8'h00});
    pri_diff   = $signed({primary_sample[31], primary_sample}) - 33'(ofs_term);
    pri_prod   = pri_diff * $signed({1'b0, st.pri_gain});
    pri_scaled = pri_prod[57:`PRI_GAIN_SHIFT];
    if (pri_scaled[35:31] == {5{pri_scaled[31]}}) begin
      pri_clip = pri_scaled[31:0];
    end else begin
      pri_clip = pri_scaled[35] ? 32'h80000000 : 32'h7FFFFFFF;
    end
    aux_diff   = $signed({aux_sample[23], aux_sample}) -
                 $signed({st.aux_ofs[15], st.aux_ofs, 8'h00});
    aux_prod   = aux_diff * $signed({1'b0, st.aux_gain});
    aux_scaled = aux_prod[41:`AUX_GAIN_SHIFT];
    if (aux_scaled[27:23] == {5{aux_scaled[23]}}) begin
      aux_clip = aux_scaled[23:0];
    end else begin
      aux_clip = aux_scaled[27] ? 24'h800000 : 24'h7FFFFF;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic               cmd_event;
  logic               is_pri;
  logic               take;
  logic signed [35:0] total;
  logic signed [31:0] avg;
  logic [32:0]        rem_sh;

  always_comb begin
    next_st           = st;
    next_st.tog_meta  = link_toggle;
    next_st.tog_sync  = st.tog_meta;
    next_st.tog_seen  = st.tog_sync;
    next_st.pin_meta  = reset_powerdown_pin;
    next_st.pin_sync  = st.pin_meta;
    next_st.pri_valid = 1'b0;
    next_st.aux_valid = 1'b0;
    next_st.restart   = 1'b0;
    cmd_event = st.operational && (st.tog_sync != st.tog_seen);
    is_pri = (st.kind == cal_pkg::primary_system_offset_cal_cmd) ||
             (st.kind == cal_pkg::primary_system_gain_cal_cmd);
    take   = is_pri ? primary_sample_valid : aux_sample_valid;
    total  = st.accum + (is_pri ? 36'(signed'(primary_sample)) : 36'(signed'(aux_sample)));
    avg    = total[35:`CAL_AVG_SHIFT];
    rem_sh = {st.rem[31:0], st.dividend[55]};

    if (!st.operational) begin
      next_st.por_count = st.por_count + 1'b1;
      if (st.por_count == `POR_COUNT_W'(POR_DELAY - 1)) begin
        next_st.operational = 1'b1;
      end
    end

    // Results, withheld while their channel is calibrating
    if (primary_sample_valid && !(st.state != cal_pkg::cal_idle && is_pri)) begin
      next_st.pri_res      = pri_clip;
      next_st.pri_valid    = 1'b1;
      next_st.data_ready_n = 1'b0;
    end
    if (aux_sample_valid && !(st.state != cal_pkg::cal_idle && !is_pri)) begin
      next_st.aux_res   = aux_clip;
      next_st.aux_valid = 1'b1;
    end

    case (st.state)
      cal_pkg::cal_idle: begin
        if (cmd_event) begin
          case (held_op)
            cal_pkg::primary_system_offset_cal_cmd,
            cal_pkg::aux_system_offset_cal_cmd,
            cal_pkg::primary_system_gain_cal_cmd,
            cal_pkg::aux_system_gain_cal_cmd: begin
              next_st.state = cal_pkg::cal_collect;
              next_st.kind  = held_op;
              next_st.count = '0;
              next_st.accum = '0;
              if (held_op == cal_pkg::primary_system_offset_cal_cmd ||
                  held_op == cal_pkg::primary_system_gain_cal_cmd) begin
                next_st.data_ready_n = 1'b1;
                next_st.pri_valid    = 1'b0;
              end else begin
                next_st.aux_busy  = 1'b1;
                next_st.aux_valid = 1'b0;
              end
            end
            cal_pkg::write_reg_cmd: begin
              case (held_addr)
                `ADDR_PRI_OFS0:  next_st.pri_ofs[7:0]   = held_data;
                `ADDR_PRI_OFS1:  next_st.pri_ofs[15:8]  = held_data;
                `ADDR_PRI_OFS2:  next_st.pri_ofs[23:16] = held_data;
                `ADDR_PRI_GAIN0: next_st.pri_gain[7:0]   = held_data;
                `ADDR_PRI_GAIN1: next_st.pri_gain[15:8]  = held_data;
                `ADDR_PRI_GAIN2: next_st.pri_gain[23:16] = held_data;
                `ADDR_AUX_OFS0:  next_st.aux_ofs[7:0]   = held_data;
                `ADDR_AUX_OFS1:  next_st.aux_ofs[15:8]  = held_data;
                `ADDR_AUX_GAIN0: next_st.aux_gain[7:0]  = held_data;
                `ADDR_AUX_GAIN1: next_st.aux_gain[15:8] = held_data;
                `ADDR_POWER: begin
                  if (!held_data[`POWER_RESET_BIT]) begin
                    next_st.reset_flag = 1'b0;
                  end
                end
                default: ;
              endcase
            end
            default: ;
          endcase
        end
      end
      cal_pkg::cal_collect: begin
        if (take) begin
          next_st.accum = total;
          next_st.count = st.count + 1'b1;
          if (st.count == `CAL_LAST_SAMPLE) begin
            case (st.kind)
              cal_pkg::primary_system_offset_cal_cmd: begin
                next_st.pri_ofs = avg[31:8];
                next_st.state   = cal_pkg::cal_store;
              end
              cal_pkg::aux_system_offset_cal_cmd: begin
                next_st.aux_ofs = avg[23:8];
                next_st.state   = cal_pkg::cal_store;
              end
              default: begin
                next_st.dividend = is_pri ? `PRI_GAIN_NUMERATOR : `AUX_GAIN_NUMERATOR;
                next_st.divisor  = {1'b0, avg};
                next_st.rem      = '0;
                next_st.quot     = '0;
                next_st.step     = '0;
                next_st.state    = cal_pkg::cal_divide;
                if (avg <= 0) begin
                  next_st.quot  = '1;
                  next_st.state = cal_pkg::cal_store;
                end
              end
            endcase
          end
        end
      end
      cal_pkg::cal_divide: begin
        next_st.dividend = {st.dividend[54:0], 1'b0};
        next_st.step     = st.step + 1'b1;
        if (rem_sh >= st.divisor) begin
          next_st.rem  = rem_sh - st.divisor;
          next_st.quot = {st.quot[54:0], 1'b1};
        end else begin
          next_st.rem  = rem_sh;
          next_st.quot = {st.quot[54:0], 1'b0};
        end
        if (st.step == `DIV_LAST_STEP) begin
          next_st.state = cal_pkg::cal_store;
        end
      end
      cal_pkg::cal_store: begin
        if (st.kind == cal_pkg::primary_system_gain_cal_cmd) begin
          next_st.pri_gain = (|st.quot[55:24]) ? `PRI_GAIN_MAX : st.quot[23:0];
        end
        if (st.kind == cal_pkg::aux_system_gain_cal_cmd) begin
          next_st.aux_gain = (|st.quot[55:16]) ? `AUX_GAIN_MAX : st.quot[15:0];
        end
        next_st.state    = cal_pkg::cal_idle;
        next_st.aux_busy = 1'b0;
        if (is_pri) begin
          next_st.data_ready_n = 1'b0;
        end
      end
      default: next_st.state = cal_pkg::cal_idle;
    endcase

    // Reset from pin or command; setting the flag wins over a clear
    if (!st.pin_sync || (cmd_event && held_op == cal_pkg::reset_cmd)) begin
      next_st.state        = cal_pkg::cal_idle;
      next_st.pri_ofs      = `PRI_OFS_DEFAULT;
      next_st.pri_gain     = `PRI_GAIN_DEFAULT;
      next_st.aux_ofs      = `AUX_OFS_DEFAULT;
      next_st.aux_gain     = `AUX_GAIN_DEFAULT;
      next_st.data_ready_n = 1'b1;
      next_st.pri_valid    = 1'b0;
      next_st.aux_valid    = 1'b0;
      next_st.aux_busy     = 1'b0;
      next_st.restart      = 1'b1;
      next_st.reset_flag   = 1'b1;
    end

    case (rd_addr)
      `ADDR_POWER:     next_st.rd_data = 8'(st.reset_flag) << `POWER_RESET_BIT;
      `ADDR_PRI_OFS0:  next_st.rd_data = st.pri_ofs[7:0];
      `ADDR_PRI_OFS1:  next_st.rd_data = st.pri_ofs[15:8];
      `ADDR_PRI_OFS2:  next_st.rd_data = st.pri_ofs[23:16];
      `ADDR_PRI_GAIN0: next_st.rd_data = st.pri_gain[7:0];
      `ADDR_PRI_GAIN1: next_st.rd_data = st.pri_gain[15:8];
      `ADDR_PRI_GAIN2: next_st.rd_data = st.pri_gain[23:16];
      `ADDR_AUX_OFS0:  next_st.rd_data = st.aux_ofs[7:0];
      `ADDR_AUX_OFS1:  next_st.rd_data = st.aux_ofs[15:8];
      `ADDR_AUX_GAIN0: next_st.rd_data = st.aux_gain[7:0];
      `ADDR_AUX_GAIN1: next_st.rd_data = st.aux_gain[15:8];
      default:         next_st.rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st              <= '0;
      st.pin_meta     <= 1'b1;
      st.pin_sync     <= 1'b1;
      st.state        <= cal_pkg::cal_idle;
      st.kind         <= cal_pkg::nop_cmd;
      st.pri_gain     <= `PRI_GAIN_DEFAULT;
      st.aux_gain     <= `AUX_GAIN_DEFAULT;
      st.reset_flag   <= 1'b1;
      st.data_ready_n <= 1'b1;
      st.restart      <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data              = st.rd_data;
  assign data_ready_n         = st.data_ready_n;
  assign primary_result       = st.pri_res;
  assign primary_result_valid = st.pri_valid;
  assign aux_result           = st.aux_res;
  assign aux_result_valid     = st.aux_valid;
  assign aux_cal_busy         = st.aux_busy;
  assign reset_flag           = st.reset_flag;
  assign status_byte          = 8'(st.reset_flag) << `STATUS_RESET_BIT;
  assign power_reg            = 8'(st.reset_flag) << `POWER_RESET_BIT;
  assign operational          = st.operational;
  assign conv_restart         = st.restart;

endmodule

`default_nettype wire

// >>> design/cal_reset_defs.svh
// Constants for the calibration and reset controller
`ifndef CAL_RESET_DEFS_SVH
`define CAL_RESET_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define POR_DELAY_CYCLES     65536
`define POR_COUNT_W          17
`define CAL_LAST_SAMPLE      5'h0F
`define CAL_AVG_SHIFT        4
`define DIV_LAST_STEP        6'h37

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_POWER           8'h01
`define ADDR_PRI_OFS0        8'h07
`define ADDR_PRI_OFS1        8'h08
`define ADDR_PRI_OFS2        8'h09
`define ADDR_PRI_GAIN0       8'h0A
`define ADDR_PRI_GAIN1       8'h0B
`define ADDR_PRI_GAIN2       8'h0C
`define ADDR_AUX_OFS0        8'h17
`define ADDR_AUX_OFS1        8'h18
`define ADDR_AUX_GAIN0       8'h19
`define ADDR_AUX_GAIN1       8'h1A

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define POWER_RESET_BIT      4
`define STATUS_RESET_BIT     0
`define PRI_OFS_DEFAULT      24'h000000
`define PRI_GAIN_DEFAULT     24'h400000
`define AUX_OFS_DEFAULT      16'h0000
`define AUX_GAIN_DEFAULT     16'h4000
`define PRI_GAIN_SHIFT       22
`define AUX_GAIN_SHIFT       14
// Positive full-scale code times the normalisation factor
`define PRI_GAIN_NUMERATOR   56'h1FFFFFFFC00000
`define AUX_GAIN_NUMERATOR   56'h00001FFFFFC000
`define PRI_GAIN_MAX         24'hFFFFFF
`define AUX_GAIN_MAX         16'hFFFF

`endif

// >>> design/cal_pkg.sv
// Types shared by the calibration and reset controller
package cal_pkg;

  typedef enum logic [2:0] {
    nop_cmd                        = 3'h0,
    reset_cmd                      = 3'h1,
    primary_system_offset_cal_cmd  = 3'h2,
    aux_system_offset_cal_cmd      = 3'h3,
    primary_system_gain_cal_cmd    = 3'h4,
    aux_system_gain_cal_cmd        = 3'h5,
    write_reg_cmd                  = 3'h6
  } cmd_op_e;

  typedef enum logic [1:0] {
    cal_idle    = 2'h0,
    cal_collect = 2'h1,
    cal_divide  = 2'h3,
    cal_store   = 2'h2
  } cal_state_e;

endpackage

// >>> design/link_cmd_port.sv
// Link-side command capture with toggle hand-off to the core clock
`timescale 1ns/10ps
`default_nettype none

module link_cmd_port (
  input  wire logic            link_clk,
  input  wire logic            rst_b,
  input  wire logic            cmd_valid,
  input  wire cal_pkg::cmd_op_e cmd_op,
  input  wire logic [7:0]      cmd_addr,
  input  wire logic [7:0]      cmd_data,
  output logic                 cmd_toggle,
  output cal_pkg::cmd_op_e     held_op,
  output logic [7:0]           held_addr,
  output logic [7:0]           held_data
);

  typedef struct packed {
    logic             toggle;
    cal_pkg::cmd_op_e op;
    logic [7:0]       addr;
    logic [7:0]       data;
  } link_s;

  link_s st;
  link_s next_st;

  // ----------------------------------------------------------------
  // Capture and toggle
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (cmd_valid) begin
      next_st.toggle = ~st.toggle;
      next_st.op     = cmd_op;
      next_st.addr   = cmd_addr;
      next_st.data   = cmd_data;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_toggle = st.toggle;
  assign held_op    = st.op;
  assign held_addr  = st.addr;
  assign held_data  = st.data;

endmodule

`default_nettype wire

// >>> testbench/cal_reset_ctrl_checker.sv
// Concurrent checks on the calibration and reset controller ports
`timescale 1ns/10ps
`default_nettype none
module cal_reset_ctrl_checker #(
  parameter int POR_DELAY = 16
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       reset_powerdown_pin,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       data_ready_n,
  input wire logic       primary_result_valid,
  input wire logic       aux_sample_valid,
  input wire logic       aux_result_valid,
  input wire logic       aux_cal_busy,
  input wire logic       reset_flag,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] power_reg,
  input wire logic       operational,
  input wire logic       conv_restart
);
  int edges;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edges <= 0;
    end else if (edges <= POR_DELAY) begin
      edges <= edges + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_oper_delay: assert property (operational == (edges >= POR_DELAY))
    else $error("operational at wrong cycle");
  a_flag_status: assert property (status_byte == {7'h00, reset_flag})
    else $error("status byte flag wrong");
  a_flag_power: assert property (power_reg == {3'h0, reset_flag, 4'h0})
    else $error("power register flag wrong");
  a_flag_cause: assert property ($rose(reset_flag) |-> conv_restart)
    else $error("flag set without a reset");
  a_pin_restart: assert property (!reset_powerdown_pin [*4] |-> conv_restart && reset_flag)
    else $error("pin reset not applied");
  a_data_ready_n_result: assert property (primary_result_valid |-> !data_ready_n)
    else $error("result while data ready high");
  a_data_ready_n_cal_end: assert property ($rose(data_ready_n) && !conv_restart |-> ##[1:1000] !data_ready_n)
    else $error("primary calibration did not end");
  a_aux_cal_end: assert property ($rose(aux_cal_busy) |-> aux_cal_busy [*8] ##[1:1000] !aux_cal_busy)
    else $error("aux calibration length wrong");
  a_aux_quiet: assert property (aux_cal_busy |-> !aux_result_valid)
    else $error("aux result during calibration");
  a_aux_latency: assert property (aux_sample_valid && !aux_cal_busy && !conv_restart
    ##1 !aux_cal_busy && !conv_restart |-> aux_result_valid)
    else $error("aux result missing");
  a_unmapped_rd: assert property (rd_addr == 8'h30 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  c_oper: cover property ($rose(operational));
  c_pri_cal: cover property ($fell(data_ready_n));
  c_aux_cal: cover property ($fell(aux_cal_busy));
endmodule
bind cal_reset_ctrl cal_reset_ctrl_checker #(.POR_DELAY(POR_DELAY)) i_cal_reset_ctrl_checker (
  .clk(clk), .rst_b(rst_b), .reset_powerdown_pin(reset_powerdown_pin), .rd_addr(rd_addr),
  .rd_data(rd_data), .data_ready_n(data_ready_n), .primary_result_valid(primary_result_valid),
  .aux_sample_valid(aux_sample_valid), .aux_result_valid(aux_result_valid),
  .aux_cal_busy(aux_cal_busy), .reset_flag(reset_flag), .status_byte(status_byte),
  .power_reg(power_reg), .operational(operational), .conv_restart(conv_restart)
);
`default_nettype wire

// >>> testbench/host_model.sv
// Host model sending commands over a gated link clock
`timescale 1ns/10ps
`default_nettype none
module host_model (
  output logic             link_clk,
  output logic             cmd_valid,
  output cal_pkg::cmd_op_e cmd_op,
  output logic [7:0]       cmd_addr,
  output logic [7:0]       cmd_data
);
  initial begin
    link_clk = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = cal_pkg::nop_cmd;
    cmd_addr = 8'h00;
    cmd_data = 8'h00;
  end
  // One frame, then the clock stands still
  task automatic send(input cal_pkg::cmd_op_e op, input logic [7:0] a, input logic [7:0] d);
    #3;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    #6 link_clk = 1'b1;
    #1;
    cmd_valid = 1'b0;
    cmd_addr = ~a;
    cmd_data = ~d;
    #5 link_clk = 1'b0;
    #6 link_clk = 1'b1;
    #6 link_clk = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/cal_reset_ctrl_tb_top.sv
// Testbench for the calibration and reset controller
`timescale 1ns/10ps
`default_nettype none
module cal_reset_ctrl_tb_top;
  logic             clk = 1'b0, rst_b = 1'b0, reset_powerdown_pin = 1'b1, chop_enable = 1'b0;
  logic             link_clk, cmd_valid, data_ready_n, aux_cal_busy, reset_flag;
  logic             primary_sample_valid = 1'b0, aux_sample_valid = 1'b0;
  logic             primary_result_valid, aux_result_valid, operational, conv_restart;
  cal_pkg::cmd_op_e cmd_op;
  logic [7:0]       cmd_addr, cmd_data, rd_data, status_byte, power_reg, rd_addr = 8'h00;
  logic [31:0]      primary_sample = 32'h0, primary_result, pri_x = 32'h0;
  logic [23:0]      aux_sample = 24'h0, aux_result, aux_x = 24'h0;
  int               phase = 0, num_errors = 0, samples_checked = 0;
  always #20 clk = ~clk;
  host_model i_host_model (.link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data));
  cal_reset_ctrl #(.POR_DELAY(16)) i_cal_reset_ctrl (.clk(clk), .rst_b(rst_b),
    .link_clk(link_clk), .reset_powerdown_pin(reset_powerdown_pin), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .chop_enable(chop_enable),
    .primary_sample_valid(primary_sample_valid), .primary_sample(primary_sample),
    .aux_sample_valid(aux_sample_valid), .aux_sample(aux_sample), .rd_addr(rd_addr),
    .rd_data(rd_data), .data_ready_n(data_ready_n), .primary_result(primary_result),
    .primary_result_valid(primary_result_valid), .aux_result(aux_result),
    .aux_result_valid(aux_result_valid), .aux_cal_busy(aux_cal_busy),
    .reset_flag(reset_flag), .status_byte(status_byte), .power_reg(power_reg),
    .operational(operational), .conv_restart(conv_restart));
  // Conversions run continuously on both channels
  always @(posedge clk) begin
    phase <= (phase + 1) % 4;
    primary_sample_valid <= (phase == 0);
    aux_sample_valid <= (phase == 2);
    primary_sample <= pri_x;
    aux_sample <= aux_x;
  end
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return data_ready_n;
      1: return aux_cal_busy;
      2: return operational;
      3: return primary_result_valid;
      default: return aux_result_valid;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic lvl);
    int n;
    n = 0;
    while (pick(w) !== lvl && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      $display("[FAIL] wait %0d expected %b seen %b", w, lvl, pick(w));
      print_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    #1;
    chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, rd_data});
  endtask
  task automatic cmd(input cal_pkg::cmd_op_e op, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    i_host_model.send(op, a, d);
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic res_chk(input logic aux, input logic [31:0] e);
    wait_for(aux ? 4 : 3, 1'b1);
    @(posedge clk);
    #1;
    wait_for(aux ? 4 : 3, 1'b1);
    chk("result", e, aux ? {8'h0, aux_result} : primary_result);
  endtask
  task automatic test_por();
    logic [7:0] addr [12];
    logic [7:0] dflt [12];
    addr = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h01, 8'h30};
    dflt = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h40, 8'h10, 8'h00};
    @(posedge clk);
    #1;
    chk("operational", 32'h0, {31'h0, operational});
    chk("status", 32'h01, {24'h0, status_byte});
    wait_for(2, 1'b1);
    for (int i = 0; i < 12; i++) rd(addr[i], dflt[i]);
  endtask
  task automatic test_flag_clear();
    cmd(cal_pkg::write_reg_cmd, 8'h01, 8'h00);
    chk("flag", 32'h0, {31'h0, reset_flag});
    cmd(cal_pkg::write_reg_cmd, 8'h01, 8'h10);
    chk("flag", 32'h0, {31'h0, reset_flag});
  endtask
  task automatic test_user_coeff();
    pri_x = 32'h00100000;
    cmd(cal_pkg::write_reg_cmd, 8'h07, 8'h01);
    cmd(cal_pkg::write_reg_cmd, 8'h0C, 8'h20);
    rd(8'h0C, 8'h20);
    rd(8'h08, 8'h00);
    res_chk(1'b0, 32'h0007FF80);
    @(posedge clk);
    chop_enable <= 1'b1;
    res_chk(1'b0, 32'h00080000);
    pri_x = 32'h7FFFFFFF;
    cmd(cal_pkg::write_reg_cmd, 8'h0C, 8'h7F);
    res_chk(1'b0, 32'h7FFFFFFF);
    @(posedge clk);
    chop_enable <= 1'b0;
  endtask
  task automatic test_pin_reset();
    @(posedge clk);
    reset_powerdown_pin <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("restart", 32'h1, {31'h0, conv_restart});
    @(posedge clk);
    reset_powerdown_pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("flag", 32'h1, {31'h0, reset_flag});
    rd(8'h0C, 8'h40);
    rd(8'h07, 8'h00);
  endtask
  task automatic test_aux_cal();
    aux_x = 24'h012345;
    cmd(cal_pkg::aux_system_offset_cal_cmd, 8'h00, 8'h00);
    chk("busy", 32'h1, {31'h0, aux_cal_busy});
    wait_for(1, 1'b0);
    rd(8'h17, 8'h23);
    rd(8'h18, 8'h01);
    res_chk(1'b1, 32'h00000045);
    aux_x = 24'h400000;
    cmd(cal_pkg::aux_system_gain_cal_cmd, 8'h00, 8'h00);
    wait_for(1, 1'b0);
    rd(8'h19, 8'hFF);
    rd(8'h1A, 8'h7F);
  endtask
  task automatic test_pri_gain();
    pri_x = 32'h00001200;
    cmd(cal_pkg::primary_system_offset_cal_cmd, 8'h00, 8'h00);
    wait_for(0, 1'b0);
    rd(8'h07, 8'h12);
    pri_x = 32'h40000000;
    cmd(cal_pkg::primary_system_gain_cal_cmd, 8'h00, 8'h00);
    chk("data ready", 32'h1, {31'h0, data_ready_n});
    wait_for(0, 1'b0);
    rd(8'h0A, 8'hFF);
    rd(8'h0C, 8'h7F);
    res_chk(1'b0, 32'h7FFFDB00);
  endtask
  task automatic test_reset_cmd();
    cmd(cal_pkg::write_reg_cmd, 8'h01, 8'h00);
    cmd(cal_pkg::reset_cmd, 8'h00, 8'h00);
    chk("power", 32'h10, {24'h0, power_reg});
    rd(8'h0A, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    test_por();
    test_flag_clear();
    test_user_coeff();
    test_pin_reset();
    test_aux_cal();
    test_pri_gain();
    test_reset_cmd();
    print_verdict();
  end
endmodule
`default_nettype wire
